// ==== rtl/yfu_unpacker.sv ====
// planar / semiplanar yuv frame unpacker with its output fifo
`timescale 1ns/10ps
`default_nettype none

// -----------------------------------------------------------------
// output fifo with a registered read stage
// -----------------------------------------------------------------
module yfu_fifo #(
   parameter int W     = 25,
   parameter int DEPTH = 32
) (
   input  wire logic         clk,        // system clock
   input  wire logic         rst_n,      // async reset, active low
   input  wire logic         ce,         // clock enable
   input  wire logic         in_valid,   // write request
   output logic              in_ready,   // room left
   input  wire logic [W-1:0] in_data,    // write data
   output logic              out_valid,  // read stage holds data
   input  wire logic         out_ready,  // consumer takes data
   output logic [W-1:0]      out_data    // read stage data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // the count is one bit wider than the pointers so that a full store is told from an empty one
   assign in_ready = (cnt_q < (AW+1)'(DEPTH));
   assign push     = ce && in_valid && in_ready;
   assign pop      = ce && (cnt_q != '0) && (!out_valid || out_ready);

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + AW'(1);
         if (pop)
            rd_q <= rd_q + AW'(1);
         if (push && !pop)
            cnt_q <= cnt_q + (AW+1)'(1);
         else if (pop && !push)
            cnt_q <= cnt_q - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end
      else if (pop)
      begin
         out_valid <= 1'b1;
         out_data  <= mem_q[rd_q];
      end
      else if (ce && out_ready)
         out_valid <= 1'b0;
   end
endmodule // yfu_fifo

// What this block does
// - In 4:2:2 planar mode luma sample n of a word comes from byte lane n, lowest lane first.
// - In 4:2:2 planar mode chroma sample n of a word comes from byte lane n, lowest lane first.
// - In planar modes Y, Cr and Cb sit in three separate planes, each in raster order, fetched separately.
// - Every plane starts on a word boundary, so only whole aligned words are fetched.
// - In 4:2:0 planar mode luma samples 0 to 3 come from bytes 0 to 3 of the first word.
// - In 4:2:0 planar mode luma continues in the next word, sample index equal to byte offset.
// - In 4:2:0 planar mode chroma samples 0 to 3 come from bytes 0 to 3 of the first word.
// - In 4:2:0 planar mode chroma samples 4 to 7 come from bytes 4 to 7, the next word.
// - In 4:2:0 semiplanar mode each luma word gives four samples, lane 0 first.
// - In 4:2:0 semiplanar mode chroma words hold Cr0, Cb0, Cr1, Cb1 from lane 0 upward.
// - For 4:2:2 one chroma pair serves two horizontally adjacent pixels.
// - For 4:2:0 one chroma pair serves a two-by-two pixel block, so a chroma line is used twice.
module yfu_unpacker #(
   parameter int DIM_W      = 12,
   parameter int FIFO_DEPTH = yfu_pkg::YFU_FIFO_DEPTH
) (
   input  wire logic             clk,         // 125 MHz system clock
   input  wire logic             rst_n,       // async reset, active low
   input  wire logic             ce,          // clock enable, freezes all state
   input  wire logic             start,       // begin one frame
   input  wire logic [1:0]       cfg_mode,    // input format
   input  wire logic [31:0]      cfg_y_base,  // luma plane base
   input  wire logic [31:0]      cfg_cr_base, // cr plane, or interleaved plane
   input  wire logic [31:0]      cfg_cb_base, // cb plane
   input  wire logic [DIM_W-1:0] cfg_width,   // pixels per line, multiple of 8
   input  wire logic [DIM_W-1:0] cfg_height,  // lines per frame
   output logic                  busy,        // frame in progress
   output logic                  mem_req,     // word read request
   output logic [31:0]           mem_addr,    // word address
   input  wire logic             mem_rvalid,  // read data returned
   input  wire logic [31:0]      mem_rdata,   // read data
   output logic                  pix_valid,   // pixel available
   input  wire logic             pix_ready,   // sink takes pixel
   output logic [7:0]            pix_y,       // luminance
   output logic [7:0]            pix_cb,      // blue chroma
   output logic [7:0]            pix_cr,      // red chroma
   output logic                  pix_last     // last pixel of frame
);
   if (DIM_W < 4)
   begin : g_bad_dim
      $error("dimension width too small");
   end

   // -----------------------------------------------------------------
   // byte lane pick
   // -----------------------------------------------------------------
   function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] idx);
      lane = w[idx*yfu_pkg::YFU_BYTE_W +: yfu_pkg::YFU_BYTE_W];
   endfunction

   yfu_pkg::yfu_state_type state_q;
   logic [1:0]        mode_q;
   logic [31:0]       y_addr_q;
   logic [31:0]       cr_addr_q;
   logic [31:0]       cb_addr_q;
   logic [31:0]       cr_line_q;
   logic [31:0]       cb_line_q;
   logic [31:0]       y_word_q;
   logic [31:0]       cr_word_q;
   logic [31:0]       cb_word_q;
   logic [DIM_W-1:0]  col_q;
   logic [DIM_W-1:0]  row_q;
   logic [DIM_W-1:0]  width_q;
   logic [DIM_W-1:0]  height_q;
   logic [1:0]        k_q;
   logic              semi;
   logic              push;
   logic              in_ready;
   logic              line_end;
   logic              frame_end;
   logic [1:0]        cidx;
   logic [7:0]        px_y;
   logic [7:0]        px_cr;
   logic [7:0]        px_cb;

   assign semi      = (mode_q == yfu_pkg::YFU_MODE_420SP);
   assign push      = ce && (state_q == yfu_pkg::ST_EMIT) && in_ready;
   assign line_end  = (col_q + DIM_W'(4)) == width_q;
   assign frame_end = line_end && (row_q + DIM_W'(1)) == height_q;
   // planar: two pixels per chroma sample, eight pixels per chroma word
   assign cidx      = {col_q[2], k_q[1]};

   // -----------------------------------------------------------------
   // pixel assembly
   // -----------------------------------------------------------------
   always_comb
   begin
      px_y = lane(y_word_q, k_q);
      if (semi)
      begin
         px_cr = lane(cr_word_q, {k_q[1], yfu_pkg::YFU_SP_CR[0]});
         px_cb = lane(cr_word_q, {k_q[1], yfu_pkg::YFU_SP_CB[0]});
      end
      else
      begin
         px_cr = lane(cr_word_q, cidx);
         px_cb = lane(cb_word_q, cidx);
      end
   end

   // -----------------------------------------------------------------
   // fetch sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q   <= yfu_pkg::ST_IDLE;
         mode_q    <= yfu_pkg::YFU_MODE_422P;
         {y_addr_q, cr_addr_q, cb_addr_q, cr_line_q, cb_line_q} <= '0;
         {y_word_q, cr_word_q, cb_word_q} <= '0;
         {col_q, row_q, width_q, height_q} <= '0;
         k_q       <= '0;
         mem_req   <= 1'b0;
         mem_addr  <= '0;
         busy      <= 1'b0;
      end
      else if (ce)
      begin
         case (state_q)
            yfu_pkg::ST_IDLE:
               if (start)
               begin
                  mode_q    <= cfg_mode;
                  // planes kept apart, each on a word boundary
                  y_addr_q  <= {cfg_y_base[31:2], yfu_pkg::YFU_ALIGN_0};
                  cr_addr_q <= {cfg_cr_base[31:2], yfu_pkg::YFU_ALIGN_0};
                  cb_addr_q <= {cfg_cb_base[31:2], yfu_pkg::YFU_ALIGN_0};
                  cr_line_q <= {cfg_cr_base[31:2], yfu_pkg::YFU_ALIGN_0};
                  cb_line_q <= {cfg_cb_base[31:2], yfu_pkg::YFU_ALIGN_0};
                  width_q   <= cfg_width;
                  height_q  <= cfg_height;
                  col_q     <= '0;
                  row_q     <= '0;
                  busy      <= 1'b1;
                  mem_req   <= 1'b1;
                  mem_addr  <= {cfg_y_base[31:2], yfu_pkg::YFU_ALIGN_0};
                  state_q   <= yfu_pkg::ST_LUMA;
               end
            yfu_pkg::ST_LUMA:
               if (mem_rvalid)
               begin
                  y_word_q <= mem_rdata;
                  y_addr_q <= y_addr_q + yfu_pkg::YFU_WORD_STEP;
                  // semiplanar needs a chroma word per luma word, planar one per two
                  if (semi || col_q[2:0] == 3'h0)
                  begin
                     mem_addr <= cr_addr_q;
                     state_q  <= yfu_pkg::ST_CR;
                  end
                  else
                  begin
                     mem_req <= 1'b0;
                     k_q     <= '0;
                     state_q <= yfu_pkg::ST_EMIT;
                  end
               end
            yfu_pkg::ST_CR:
               if (mem_rvalid)
               begin
                  cr_word_q <= mem_rdata;
                  cr_addr_q <= cr_addr_q + yfu_pkg::YFU_WORD_STEP;
                  if (semi)
                  begin
                     mem_req <= 1'b0;
                     k_q     <= '0;
                     state_q <= yfu_pkg::ST_EMIT;
                  end
                  else
                  begin
                     mem_addr <= cb_addr_q;
                     state_q  <= yfu_pkg::ST_CB;
                  end
               end
            yfu_pkg::ST_CB:
               if (mem_rvalid)
               begin
                  cb_word_q <= mem_rdata;
                  cb_addr_q <= cb_addr_q + yfu_pkg::YFU_WORD_STEP;
                  mem_req   <= 1'b0;
                  k_q       <= '0;
                  state_q   <= yfu_pkg::ST_EMIT;
               end
            yfu_pkg::ST_EMIT:
               if (in_ready)
               begin
                  k_q <= k_q + 2'h1;
                  if (k_q == 2'h3)
                  begin
                     col_q <= line_end ? '0 : col_q + DIM_W'(4);
                     if (line_end)
                     begin
                        row_q <= row_q + DIM_W'(1);
                        // 4:2:0 chroma line serves two luma lines: replay it once
                        if (mode_q != yfu_pkg::YFU_MODE_422P && !row_q[0])
                        begin
                           cr_addr_q <= cr_line_q;
                           cb_addr_q <= cb_line_q;
                        end
                        else
                        begin
                           cr_line_q <= cr_addr_q;
                           cb_line_q <= cb_addr_q;
                        end
                     end
                     if (frame_end)
                     begin
                        busy    <= 1'b0;
                        state_q <= yfu_pkg::ST_IDLE;
                     end
                     else
                     begin
                        mem_req  <= 1'b1;
                        mem_addr <= y_addr_q;
                        state_q  <= yfu_pkg::ST_LUMA;
                     end
                  end
               end
            default:
               state_q <= yfu_pkg::ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // output buffer: a stalled sink stops the fetcher once it is full
   // -----------------------------------------------------------------
   yfu_fifo #(
      .W     (yfu_pkg::YFU_PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (state_q == yfu_pkg::ST_EMIT),
      .in_ready  (in_ready),
      .in_data   ({frame_end && k_q == 2'h3, px_cr, px_cb, px_y}),
      .out_valid (pix_valid),
      .out_ready (pix_ready),
      .out_data  ({pix_last, pix_cr, pix_cb, pix_y})
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   fetch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr))
      else $error("read request dropped or address moved while waiting");
   word_align_a: assert property (@(posedge clk) disable iff (!rst_n)
      mem_req |-> mem_addr[1:0] == yfu_pkg::YFU_ALIGN_0)
      else $error("unaligned word fetch");
   plane_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state_q == yfu_pkg::ST_IDLE && start |=>
      mem_req && mem_addr[31:2] == $past(cfg_y_base[31:2]) && cr_addr_q[31:2] == $past(cfg_cr_base[31:2]))
      else $error("frame did not start at the luma plane base");
   luma_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && state_q == yfu_pkg::ST_LUMA && mem_rvalid |=>
      y_addr_q == $past(y_addr_q) + yfu_pkg::YFU_WORD_STEP && $stable(cb_addr_q))
      else $error("luma address did not advance by one word alone");
   luma_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
      push && k_q == 2'h2 |-> px_y == y_word_q[23:16])
      else $error("luma sample 2 not from byte lane 2");
   planar_chroma_a: assert property (@(posedge clk) disable iff (!rst_n)
      push && !semi && col_q[2] && k_q == 2'h3 |-> px_cr == cr_word_q[31:24])
      else $error("planar chroma lane wrong");
   semi_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
      push && semi && k_q == 2'h2 |-> px_cr == cr_word_q[23:16] && px_cb == cr_word_q[31:24])
      else $error("semiplanar chroma pair wrong");
   chroma_replay_a: assert property (@(posedge clk) disable iff (!rst_n)
      push && k_q == 2'h3 && line_end && !row_q[0] && mode_q == yfu_pkg::YFU_MODE_420P
      |=> cr_addr_q == $past(cr_line_q))
      else $error("4:2:0 chroma line not replayed");
endmodule // yfu_unpacker
`default_nettype wire

// ==== common/yfu_pkg.sv ====
// shared constants for the planar yuv frame unpacker
`default_nettype none
package yfu_pkg;
   // -----------------------------------------------------------------
   // memory layout
   // -----------------------------------------------------------------
   localparam int          YFU_BYTE_W    = 8;
   localparam int          YFU_WORD_W    = 32;
   localparam int          YFU_LANES     = 4;
   localparam logic [31:0] YFU_WORD_STEP = 32'h0000_0004;
   localparam logic [1:0]  YFU_ALIGN_0   = 2'h0;
   // semiplanar chroma pair: cr in the even lane, cb in the odd lane
   localparam logic [1:0]  YFU_SP_CR     = 2'h0;
   localparam logic [1:0]  YFU_SP_CB     = 2'h1;
   // -----------------------------------------------------------------
   // input formats
   // -----------------------------------------------------------------
   localparam logic [1:0]  YFU_MODE_422P  = 2'h0;
   localparam logic [1:0]  YFU_MODE_420P  = 2'h1;
   localparam logic [1:0]  YFU_MODE_420SP = 2'h2;
   // -----------------------------------------------------------------
   // fetch sequencer
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_LUMA, ST_CR, ST_CB, ST_EMIT} yfu_state_type;
   localparam int          YFU_FIFO_DEPTH = 32;
   localparam int          YFU_PIX_W      = 25;   // last, cr, cb, y
endpackage : yfu_pkg
`default_nettype wire

// ==== testbench/yfu_tb_pkg.sv ====
// memory contents shared by the bench and the memory model
`default_nettype none
package yfu_tb_pkg;
   // -----------------------------------------------------------------
   // frame buffer pattern
   // -----------------------------------------------------------------
   // bytes are scrambled from the address, so neighbours seldom match (address 0 gives 00 in lanes 0, 2 and 3) and a lane swap nearly always shows
   function automatic logic [31:0] yfu_tb_word(input logic [31:0] addr);
      return (addr * 32'h9E37_79B1) ^ {addr[7:0], addr[15:8], 8'hC3, addr[23:16]};
   endfunction
endpackage : yfu_tb_pkg
`default_nettype wire

// ==== testbench/yfu_mem_model.sv ====
// system memory holding the luma and chroma planes
`timescale 1ns/10ps
`default_nettype none
module yfu_mem_model (
   input  wire logic        clk,        // system clock
   input  wire logic        rst_n,      // async reset, active low
   input  wire logic        ce,         // clock enable seen by the design
   input  wire logic        slow,       // answer after random wait states
   input  wire logic        mem_req,    // word read request
   input  wire logic [31:0] mem_addr,   // word address
   output logic             mem_rvalid, // read data returned
   output logic [31:0]      mem_rdata   // read data
);
   logic [3:0] wait_q;

   // -----------------------------------------------------------------
   // read responder
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= 32'h0000_0000;
         wait_q     <= 4'h0;
      end
      else if (mem_rvalid)
      begin
         // the answer only counts at an enabled edge, so hold it until then
         if (ce)
         begin
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
         end
      end
      else if (mem_req && wait_q == 4'h0)
      begin
         mem_rvalid <= 1'b1;
         // each plane lives at its own addresses, read as whole aligned words
         mem_rdata  <= yfu_tb_pkg::yfu_tb_word({mem_addr[31:2], 2'h0});
         wait_q     <= slow ? 4'($urandom_range(6, 0)) : 4'h0;
      end
      else
      begin
         if (mem_req)
            wait_q <= wait_q - 4'h1;
         // released data bus never keeps a stale word
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule // yfu_mem_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the planar yuv frame unpacker
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module testbench;
   logic        clk, rst_n, ce, start, slow, busy, pix_ready;
   logic        mem_req, mem_rvalid, pix_valid, pix_last;
   logic [1:0]  cfg_mode;
   logic [31:0] cfg_y_base, cfg_cr_base, cfg_cb_base, mem_addr, mem_rdata, plane_end;
   logic [11:0] cfg_width, cfg_height;
   logic [7:0]  pix_y, pix_cb, pix_cr;
   int          failures, checked;

   always #4 clk = ~clk;

   yfu_unpacker DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .cfg_mode(cfg_mode),
      .cfg_y_base(cfg_y_base), .cfg_cr_base(cfg_cr_base), .cfg_cb_base(cfg_cb_base),
      .cfg_width(cfg_width), .cfg_height(cfg_height), .busy(busy), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_y(pix_y), .pix_cb(pix_cb),
      .pix_cr(pix_cr), .pix_last(pix_last));

   yfu_mem_model u_mem (.clk(clk), .rst_n(rst_n), .ce(ce), .slow(slow), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

   // -----------------------------------------------------------------
   // expected pixels
   // -----------------------------------------------------------------
   function automatic logic [7:0] byte_at(input logic [31:0] a);
      logic [31:0] wd;
      wd = yfu_tb_pkg::yfu_tb_word({a[31:2], 2'h0});
      return wd[8*a[1:0] +: 8];
   endfunction

   function automatic logic [23:0] exp_pix(input logic [1:0] m, input int w, input int r,
                                           input int c);
      int          cr_row;
      logic [31:0] a;
      logic [7:0]  y, cb, cr;
      y      = byte_at(cfg_y_base + 32'(r * w + c));
      cr_row = (m == yfu_pkg::YFU_MODE_422P) ? r : r / 2;
      if (m == yfu_pkg::YFU_MODE_420SP)
      begin
         a  = cfg_cr_base + 32'(cr_row * w + (c / 2) * 2);
         cr = byte_at(a);
         cb = byte_at(a + 32'h0000_0001);
      end
      else
      begin
         cr = byte_at(cfg_cr_base + 32'(cr_row * (w / 2) + c / 2));
         cb = byte_at(cfg_cb_base + 32'(cr_row * (w / 2) + c / 2));
      end
      return {y, cb, cr};
   endfunction

   task automatic finish_test();
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // one frame: stall sets how rarely the sink is ready (0 always, 3 rarely)
   // -----------------------------------------------------------------
   task automatic run_frame(input logic [1:0] m, input int w, input int h, input logic sl,
                            input int stall);
      int          n, idx, cyc, csz;
      logic [31:0] base;
      logic [23:0] exp;
      n    = w * h;
      idx  = 0;
      csz  = (m == yfu_pkg::YFU_MODE_422P) ? n / 2 : n / 4;
      base = $urandom & 32'h00FF_FFFC;
      @(posedge clk);
      cfg_mode    <= m;
      cfg_width   <= 12'(w);
      cfg_height  <= 12'(h);
      slow        <= sl;
      // planes back to back, each on a word boundary
      cfg_y_base  <= base;
      cfg_cr_base <= base + 32'(n);
      cfg_cb_base <= base + 32'(n + csz);
      plane_end   <= base + 32'((m == yfu_pkg::YFU_MODE_420SP) ? n + n / 2 : n + 2 * csz);
      ce          <= 1'b1;
      start       <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (cyc = 0; cyc < 20000 && idx < n; cyc++)
      begin
         @(posedge clk);
         if (cyc == 0)
            `CHK(busy, 1'b1)
         if (mem_req)
         begin
            `CHK(mem_addr[1:0], yfu_pkg::YFU_ALIGN_0)
            `CHK(mem_addr >= cfg_y_base && mem_addr < plane_end, 1'b1)
         end
         if (ce && pix_valid && pix_ready)
         begin
            exp = exp_pix(m, w, idx / w, idx % w);
            case (m)
               yfu_pkg::YFU_MODE_422P: `CHK({pix_y, pix_cb, pix_cr}, exp)
               yfu_pkg::YFU_MODE_420P: `CHK({pix_y, pix_cb, pix_cr}, exp)
               default: `CHK({pix_y, pix_cb, pix_cr}, exp)
            endcase
            `CHK(pix_last, 1'(idx == n - 1))
            idx++;
         end
         ce        <= ($urandom_range(7, 0) != 0);
         pix_ready <= ($urandom_range(3, 0) >= stall);
      end
      if (idx < n)
      begin
         failures++;
         $display("CHECK FAILED t=%0t frame never completed", $time);
         finish_test();
      end
      @(posedge clk);
      // nothing left over once the frame has drained
      `CHK({busy, pix_valid, mem_req}, 3'h0)
   endtask

   // -----------------------------------------------------------------
   // main sequence: corner frame, slow-memory stalled-sink frame, random frame per mode
   // -----------------------------------------------------------------
   initial
   begin
      clk        = 1'b0;
      rst_n      = 1'b0;
      ce         = 1'b0;
      start      = 1'b0;
      slow       = 1'b0;
      pix_ready  = 1'b0;
      cfg_mode   = 2'h0;
      cfg_width  = 12'h000;
      cfg_height = 12'h000;
      cfg_y_base = 32'h0000_0000;
      cfg_cr_base = 32'h0000_0000;
      cfg_cb_base = 32'h0000_0000;
      plane_end  = 32'h0000_0000;
      failures   = 0;
      checked    = 0;
      void'($urandom(32'h4769));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int mi = 0; mi < 3; mi++)
      begin
         run_frame(2'(mi), 8, 2, 1'b0, 0);
         run_frame(2'(mi), 16, 4, 1'b1, 3);
         run_frame(2'(mi), 8 * $urandom_range(3, 1), 2 * $urandom_range(3, 1),
                   1'($urandom_range(1, 0)), $urandom_range(2, 0));
      end
      finish_test();
   end
endmodule // testbench
`default_nettype wire
